/* logic/lnbg_top.sv */
// Luma noise reduction, gamma correction and average brightness detection
// Overview of operation
// - Three-bit select picks the filter; only its passband is noise processed.
// - Mode bit 0 selects subtract mode, 1 selects sharpness mode.
// - Subtract mode: filtered part below threshold, scaled by gain, subtracted.
// - Sharpness mode: filtered part above threshold, scaled by gain, added.
// - Four-bit offset shifts block grid by up to 15 pixels.
// - Fourteen 8-bit gamma registers from address 26h hold curves A and B.
// - Gamma acts on luma only, one curve active at a time.
// - Curve outputs at 32..224 step 32 programmed, linear between points.
// - Curve points at 0, 16, 240 and 255 are fixed.
// - Read-only 8-bit average brightness register at 34h.
// - Brightness accumulates active video samples only.
// - Brightness register loads when the 8-step division started by a vertical sync falling edge ends.
// - Threshold is a six-bit absolute amplitude 0 to 63.
// - Gains 0..1 in eighths subtracting, 0..0.5 in sixteenths sharpening.
// - Block size bit 1 gives 16-pixel blocks, 0 gives 8-pixel blocks.
`timescale 1ns/1ns
`default_nettype none
module lnbg_top
    import lnbg_pkg::*;
#(
    parameter int CNTW = 20
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_PIX_VALID,
    output logic O_PIX_READY,
    input wire lnbg_pix_s I_PIX,
    output logic O_PIX_VALID,
    input wire logic I_PIX_READY,
    output lnbg_pix_s O_PIX,
    input wire logic I_VSYNC,
    input wire logic I_GAMMA_EN,
    input wire logic I_GAMMA_CURVE_B,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [5:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID
);
    localparam int SUMW = CNTW + 8;

    initial begin
        if (CNTW < 4 || CNTW > 24) $error("lnbg_top: CNTW out of range");
    end

    // Register file
    logic [7:0] nr0_ff, nr1_ff, nr2_ff, bright_ff;
    logic [7:0] gamma_ff [LNBG_GAMMA_REGS];
    wire wr_nr0 = I_REG_WR && (I_REG_ADDR == LNBG_NR0_ADDR);
    wire wr_nr1 = I_REG_WR && (I_REG_ADDR == LNBG_NR1_ADDR);
    wire wr_nr2 = I_REG_WR && (I_REG_ADDR == LNBG_NR2_ADDR);
    wire [5:0] gidx = I_REG_ADDR - LNBG_GAMMA_ADDR;
    wire gamma_hit = (I_REG_ADDR >= LNBG_GAMMA_ADDR) && (gidx < 6'(LNBG_GAMMA_REGS));
    wire [7:0] rd_mux = (I_REG_ADDR == LNBG_NR0_ADDR) ? nr0_ff :
                        (I_REG_ADDR == LNBG_NR1_ADDR) ? nr1_ff :
                        (I_REG_ADDR == LNBG_NR2_ADDR) ? nr2_ff :
                        (I_REG_ADDR == LNBG_BRIGHT_ADDR) ? bright_ff :
                        gamma_hit ? gamma_ff[gidx[3:0]] : 8'h00;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            nr0_ff <= LNBG_NR_RST;
            nr1_ff <= LNBG_NR_RST;
            nr2_ff <= LNBG_NR_RST;
            O_REG_RDATA <= 8'h00;
            O_REG_RVALID <= 1'b0;
        end else begin
            if (wr_nr0) nr0_ff <= I_REG_WDATA;
            if (wr_nr1) nr1_ff <= I_REG_WDATA;
            if (wr_nr2) nr2_ff <= I_REG_WDATA;
            O_REG_RVALID <= I_REG_RD;
            if (I_REG_RD) O_REG_RDATA <= rd_mux;
        end
    end

    // Gamma point registers, reset to a straight line
    for (genvar g = 0; g < LNBG_GAMMA_REGS; g++) begin : g_gamma
        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                gamma_ff[g] <= 8'((g % LNBG_GAMMA_PTS + 1) * LNBG_GSTEP_RST);
            end else if (I_REG_WR && gamma_hit && gidx == 6'(g)) begin
                gamma_ff[g] <= I_REG_WDATA;
            end
        end
    end

    // Control fields
    wire [2:0] sel = nr2_ff[LNBG_SEL_LSB +: 3];
    wire sharp_mode = nr2_ff[LNBG_MODE_BIT];
    wire [3:0] blk_ofs = nr2_ff[LNBG_OFS_LSB +: 4];
    wire [5:0] thr = nr1_ff[LNBG_THR_LSB +: 6];
    wire wide_border = nr1_ff[LNBG_BORDER_BIT];
    wire big_block = nr1_ff[LNBG_BSIZE_BIT];
    wire [3:0] gain_b = nr0_ff[LNBG_GB_LSB +: 4];
    wire [3:0] gain_d = nr0_ff[LNBG_GD_LSB +: 4];

    // Field boundary and curve select
    logic vs_ff, curve_ff;
    wire vs_fall = vs_ff && !I_VSYNC;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            vs_ff <= 1'b0;
            curve_ff <= 1'b0;
        end else begin
            vs_ff <= I_VSYNC;
            if (vs_fall) curve_ff <= I_GAMMA_CURVE_B;
        end
    end

    // Noise reduction datapath
    logic [7:0] hist_ff [8];
    logic [3:0] col_ff;
    logic buf_ready;
    wire take = I_PIX_VALID && buf_ready;
    wire [7:0] y_in = I_PIX.y;
    wire [7:0] nb = hist_ff[sel];
    wire signed [9:0] hp = ($signed({2'b00, y_in}) - $signed({2'b00, nb})) >>> 1;
    wire [9:0] hp_abs = hp[9] ? 10'(-hp) : hp;
    wire [3:0] blk_mask = big_block ? 4'hf : 4'h7;
    wire [3:0] pos = (col_ff + blk_ofs) & blk_mask;
    wire [3:0] half = wide_border ? 4'h2 : 4'h1;
    wire is_border = (pos < half) || (pos > (blk_mask - half));
    wire [3:0] gain_raw = is_border ? gain_b : gain_d;
    wire [4:0] gain = ({1'b0, gain_raw} > LNBG_GAIN_MAX) ? LNBG_GAIN_MAX : {1'b0, gain_raw};
    wire signed [15:0] corr = 16'(hp * $signed({1'b0, gain}));
    wire below = hp_abs < {4'h0, thr};
    wire above = hp_abs > {4'h0, thr};
    wire do_sub = !sharp_mode && below;
    wire do_add = sharp_mode && above;
    wire signed [15:0] y_ext = $signed({8'h00, y_in});
    wire signed [15:0] y_sub = y_ext - (corr >>> 3);
    wire signed [15:0] y_add = y_ext + (corr >>> 4);
    wire signed [15:0] y_nr = do_sub ? y_sub : (do_add ? y_add : y_ext);
    wire [7:0] y_clip = y_nr[15] ? 8'h00 : ((y_nr > 16'sd255) ? 8'hff : y_nr[7:0]);
    wire [7:0] dnr_y = I_PIX.act ? y_clip : y_in;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            col_ff <= 4'h0;
            for (int i = 0; i < 8; i++) hist_ff[i] <= 8'h00;
        end else if (take) begin
            col_ff <= I_PIX.act ? col_ff + 4'h1 : 4'h0;
            hist_ff[0] <= y_in;
            for (int i = 1; i < 8; i++) hist_ff[i] <= hist_ff[i-1];
        end
    end

    // Gamma correction on the active curve
    logic [LNBG_GAMMA_PTS-1:0][7:0] pts;
    for (genvar p = 0; p < LNBG_GAMMA_PTS; p++) begin : g_pts
        assign pts[p] = curve_ff ? gamma_ff[p + LNBG_GAMMA_PTS] : gamma_ff[p];
    end
    logic [7:0] gam_y;
    lnbg_gamma u_gamma (
        .i_x(dnr_y),
        .i_pts(pts),
        .o_y(gam_y)
    );
    wire use_gamma = I_GAMMA_EN && I_PIX.act;
    lnbg_pix_s out_pix;
    assign out_pix = {I_PIX.act, (use_gamma ? gam_y : dnr_y)};

    lnbg_buf #(.W($bits(lnbg_pix_s))) u_buf (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_valid(I_PIX_VALID),
        .o_ready(buf_ready),
        .i_data(out_pix),
        .o_valid(O_PIX_VALID),
        .i_ready(I_PIX_READY),
        .o_data(O_PIX)
    );
    assign O_PIX_READY = buf_ready;

    // Average brightness: accumulate, then divide serially
    logic [SUMW-1:0] sum_ff, rem_ff;
    logic [CNTW-1:0] cnt_ff, den_ff;
    logic [7:0] q_ff;
    logic [2:0] bit_ff;
    lnbg_div_e st_ff, nxt_st;
    wire act_take = take && I_PIX.act;
    wire [SUMW-1:0] den_sh = SUMW'({8'h00, den_ff} << bit_ff);
    wire fits = rem_ff >= den_sh;
    wire [7:0] q_bit = 8'(8'h01 << bit_ff);
    wire [7:0] q_fin = (den_ff == '0) ? 8'h00 : q_ff;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            LNBG_IDLE: nxt_st = vs_fall ? LNBG_DIV : LNBG_IDLE;
            LNBG_DIV: nxt_st = vs_fall ? LNBG_DIV : ((bit_ff == 3'h0) ? LNBG_LOAD : LNBG_DIV);
            LNBG_LOAD: nxt_st = vs_fall ? LNBG_DIV : LNBG_IDLE;
            default: nxt_st = LNBG_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            st_ff <= LNBG_IDLE;
            sum_ff <= '0;
            cnt_ff <= '0;
            rem_ff <= '0;
            den_ff <= '0;
            q_ff <= 8'h00;
            bit_ff <= 3'h0;
            bright_ff <= LNBG_BRIGHT_RST;
        end else begin
            st_ff <= nxt_st;
            if (vs_fall) begin
                rem_ff <= sum_ff;
                den_ff <= cnt_ff;
                q_ff <= 8'h00;
                bit_ff <= LNBG_DIV_STEPS;
                sum_ff <= act_take ? SUMW'(y_in) : '0;
                cnt_ff <= act_take ? CNTW'(1) : '0;
            end else begin
                if (act_take) begin
                    sum_ff <= sum_ff + SUMW'(y_in);
                    cnt_ff <= cnt_ff + CNTW'(1);
                end
                if (st_ff == LNBG_DIV) begin
                    if (fits) rem_ff <= rem_ff - den_sh;
                    if (fits) q_ff <= q_ff | q_bit;
                    bit_ff <= bit_ff - 3'h1;
                end
                if (st_ff == LNBG_LOAD) bright_ff <= q_fin;
            end
        end
    end

    sub_pass_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_PIX.act && !sharp_mode && !below |-> dnr_y == y_in)
        else $error("subtract mode altered a sample above threshold");
    sharp_pass_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_PIX.act && sharp_mode && !above |-> dnr_y == y_in)
        else $error("sharpness mode altered a sample below threshold");
    zero_gain_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        gain == 5'h00 |-> dnr_y == y_in)
        else $error("zero gain changed the sample");
    gamma_fixed_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (dnr_y == LNBG_G_LO || dnr_y == LNBG_G_HI || dnr_y == 8'h00 || dnr_y == 8'hff) |-> gam_y == dnr_y)
        else $error("fixed gamma point moved");
    gamma_knot_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        dnr_y == 8'h40 |-> gam_y == pts[1])
        else $error("gamma knot not taken from register");
    blank_sum_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !vs_fall && !act_take |=> $stable(sum_ff))
        else $error("blanking sample added to brightness");
    curve_edge_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $changed(curve_ff) |-> $past(vs_fall))
        else $error("gamma curve switched inside a field");
    bright_load_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        vs_fall ##1 !vs_fall [*8] |-> ##1 st_ff == LNBG_LOAD)
        else $error("brightness not loaded after vsync fall");

    // Register port and brightness register
    rd_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_REG_RVALID == $past(I_REG_RD))
        else $error("read valid not one cycle after strobe");
    rd_bright_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_REG_RD && I_REG_ADDR == LNBG_BRIGHT_ADDR |=> O_REG_RDATA == $past(bright_ff))
        else $error("brightness read returned wrong value");
    wr_thr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        wr_nr1 |=> nr1_ff == $past(I_REG_WDATA))
        else $error("threshold write did not land");
    bright_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        st_ff != LNBG_LOAD |=> $stable(bright_ff))
        else $error("brightness changed outside a load");
    div_order_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        st_ff == LNBG_LOAD |-> $past(st_ff) == LNBG_DIV)
        else $error("brightness loaded without a division");
    state_hot_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $onehot(st_ff))
        else $error("divider state not one-hot");

    // Noise and gamma path
    blank_bypass_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !I_PIX.act |-> out_pix.y == I_PIX.y)
        else $error("blanking sample was processed");
    gamma_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !I_GAMMA_EN |-> out_pix.y == dnr_y)
        else $error("gamma applied while disabled");
    gain_cap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        gain <= LNBG_GAIN_MAX)
        else $error("coring gain above ceiling");
    small_grid_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !big_block |-> pos <= 4'h7)
        else $error("small block grid position out of range");

    // Scenario covers
    sharp_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N) take && do_add);
    sub_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N) take && do_sub);
    load_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N) st_ff == LNBG_LOAD && den_ff != '0);
    gamma_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N) take && use_gamma && curve_ff);
endmodule
`default_nettype wire

/* logic/lnbg_pkg.sv */
// Shared constants and types for the luma noise, gamma and brightness block
package lnbg_pkg;
    // Register addresses on the register port
    localparam logic [5:0] LNBG_NR2_ADDR = 6'h23;
    localparam logic [5:0] LNBG_NR1_ADDR = 6'h24;
    localparam logic [5:0] LNBG_NR0_ADDR = 6'h25;
    localparam logic [5:0] LNBG_GAMMA_ADDR = 6'h26;
    localparam logic [5:0] LNBG_BRIGHT_ADDR = 6'h34;
    localparam int LNBG_GAMMA_REGS = 14;
    localparam int LNBG_GAMMA_PTS = 7;
    // Field positions
    localparam int LNBG_SEL_LSB = 0;
    localparam int LNBG_MODE_BIT = 3;
    localparam int LNBG_OFS_LSB = 4;
    localparam int LNBG_THR_LSB = 0;
    localparam int LNBG_BORDER_BIT = 6;
    localparam int LNBG_BSIZE_BIT = 7;
    localparam int LNBG_GB_LSB = 0;
    localparam int LNBG_GD_LSB = 4;
    // Reset values
    localparam logic [7:0] LNBG_NR_RST = 8'h00;
    localparam logic [7:0] LNBG_BRIGHT_RST = 8'h00;
    localparam logic [7:0] LNBG_GSTEP_RST = 8'h20;
    // Fixed curve ends, gain ceiling and divider start bit
    localparam logic [7:0] LNBG_G_LO = 8'h10;
    localparam logic [7:0] LNBG_G_HI = 8'hf0;
    localparam logic [4:0] LNBG_GAIN_MAX = 5'h08;
    localparam logic [2:0] LNBG_DIV_STEPS = 3'h7;

    typedef struct packed {
        logic act;
        logic [7:0] y;
    } lnbg_pix_s;

    typedef enum logic [2:0] {
        LNBG_IDLE = 3'b001,
        LNBG_DIV = 3'b010,
        LNBG_LOAD = 3'b100
    } lnbg_div_e;
endpackage

/* logic/lnbg_buf.sv */
// Two-entry buffer with registered valid, ready and data
`timescale 1ns/1ns
`default_nettype none
module lnbg_buf #(
    parameter int W = 9
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    logic [W-1:0] skid_ff;
    logic skid_v_ff;
    wire push = i_valid & o_ready;
    wire pop = o_valid & i_ready;
    wire nxt_skid_v = skid_v_ff ? ~pop : (push & o_valid & ~pop);

    initial begin
        if (W < 1) $error("lnbg_buf: W must be positive");
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            skid_v_ff <= 1'b0;
            o_valid <= 1'b0;
            o_ready <= 1'b0;
            o_data <= '0;
            skid_ff <= '0;
        end else begin
            skid_v_ff <= nxt_skid_v;
            o_ready <= ~nxt_skid_v;
            if (skid_v_ff && pop) begin
                o_data <= skid_ff;
            end else if (!skid_v_ff && push && o_valid && !pop) begin
                skid_ff <= i_data;
            end else if (!skid_v_ff && push) begin
                o_data <= i_data;
                o_valid <= 1'b1;
            end else if (!skid_v_ff && pop) begin
                o_valid <= 1'b0;
            end
        end
    end

    hold_stall_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && !i_ready |=> o_valid && $stable(o_data))
        else $error("buffer output changed while stalled");
    full_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        skid_v_ff |-> !o_ready && o_valid)
        else $error("buffer accepts while full");
    buf_fill_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) skid_v_ff ##1 pop);
endmodule
`default_nettype wire

/* logic/lnbg_gamma.sv */
// Seven-point piecewise linear gamma curve
`timescale 1ns/1ns
`default_nettype none
module lnbg_gamma
    import lnbg_pkg::*;
(
    input wire logic [7:0] i_x,
    input wire logic [LNBG_GAMMA_PTS-1:0][7:0] i_pts,
    output logic [7:0] o_y
);
    wire fixed = (i_x < LNBG_G_LO) || (i_x >= LNBG_G_HI);
    wire low_seg = (i_x[7:5] == 3'h0);
    wire high_seg = (i_x[7:4] == 4'he);
    wire [2:0] k = i_x[7:5] - 3'h1;
    wire [7:0] a = low_seg ? LNBG_G_LO : i_pts[k];
    wire [7:0] b = high_seg ? LNBG_G_HI : (low_seg ? i_pts[0] : i_pts[3'(k + 3'h1)]);
    wire [4:0] f = (low_seg || high_seg) ? {1'b0, i_x[3:0]} : i_x[4:0];
    wire signed [9:0] diff = $signed({2'b00, b}) - $signed({2'b00, a});
    wire signed [15:0] prod = 16'(diff * $signed({1'b0, f}));
    wire signed [15:0] step = (low_seg || high_seg) ? (prod >>> 4) : (prod >>> 5);
    wire signed [15:0] sum = $signed({8'h00, a}) + step;
    assign o_y = fixed ? i_x : sum[7:0];
endmodule
`default_nettype wire

/* sim/lnbg_src.sv */
// Pixel source and stalling sink around the luma block
`timescale 1ns/1ns
`default_nettype none
module lnbg_src
    import lnbg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_ready,
    input wire logic i_valid,
    input wire lnbg_pix_s i_pix,
    output logic o_valid,
    output lnbg_pix_s o_pix,
    output logic o_ready,
    output logic o_vsync
);
    lnbg_pix_s got[$];
    initial begin
        o_valid = 1'b0;
        o_pix = '0;
        o_vsync = 1'b0;
    end
    assign o_ready = !i_stall;
    always @(posedge i_clk) begin
        if (i_valid && o_ready) got.push_back(i_pix);
    end
    // Holds the sample until taken, then leaves garbage on the bus
    task automatic send(input logic act, input logic [7:0] y);
        int n;
        n = 0;
        @(posedge i_clk);
        #1 o_valid = 1'b1;
        o_pix = {act, y};
        do begin
            @(posedge i_clk);
            n++;
        end while (!i_ready && n < 50);
        #1 o_valid = 1'b0;
        o_pix = ~o_pix;
    endtask
    // One sync pulse; its falling edge marks the field boundary
    task automatic field_end();
        @(posedge i_clk);
        #1 o_vsync = 1'b1;
        @(posedge i_clk);
        #1 o_vsync = 1'b0;
    endtask
endmodule
`default_nettype wire

/* sim/luma_noise_gamma_brightness_test.sv */
// Self-checking bench for the luma noise, gamma and brightness block
`timescale 1ns/1ns
`default_nettype none
module luma_noise_gamma_brightness_test
    import lnbg_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic gamma_en = 1'b0;
    logic curve_b = 1'b0;
    logic stall = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic [7:0] reg_rdata;
    logic reg_rvalid, pix_valid, pix_ready, out_valid, out_ready, vsync;
    lnbg_pix_s pix, out_pix;
    int err_count = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    lnbg_top #(.CNTW(8)) i_dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_PIX_VALID(pix_valid), .O_PIX_READY(pix_ready), .I_PIX(pix),
        .O_PIX_VALID(out_valid), .I_PIX_READY(out_ready), .O_PIX(out_pix), .I_VSYNC(vsync),
        .I_GAMMA_EN(gamma_en), .I_GAMMA_CURVE_B(curve_b), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
        .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .O_REG_RDATA(reg_rdata), .O_REG_RVALID(reg_rvalid)
    );
    lnbg_src i_src (
        .i_clk(clk), .i_stall(stall), .i_ready(pix_ready), .i_valid(out_valid), .i_pix(out_pix),
        .o_valid(pix_valid), .o_pix(pix), .o_ready(out_ready), .o_vsync(vsync)
    );
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask
    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask
    task automatic reg_read(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        chk("read valid", 8'h01, {7'h00, reg_rvalid});
        chk("read data", exp, reg_rdata);
    endtask
    task automatic xfer(input logic act, input logic [7:0] y, input logic [7:0] exp);
        int n;
        lnbg_pix_s p;
        n = 0;
        p = '1;
        i_src.send(act, y);
        while (i_src.got.size() == 0 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        if (i_src.got.size() > 0) p = i_src.got.pop_front();
        chk("pixel", exp, p.y);
        chk("active flag", {7'h00, act}, {7'h00, p.act});
    endtask
    task automatic t_regs();
        for (int i = 0; i < 14; i++) reg_read(LNBG_GAMMA_ADDR + 6'(i), 8'(32 * ((i % 7) + 1)));
        for (int i = 0; i < 3; i++) reg_read(LNBG_NR2_ADDR + 6'(i), LNBG_NR_RST);
        reg_read(LNBG_BRIGHT_ADDR, LNBG_BRIGHT_RST);
        reg_write(LNBG_BRIGHT_ADDR, 8'h55);
        reg_read(LNBG_BRIGHT_ADDR, LNBG_BRIGHT_RST);
        reg_write(6'h30, 8'ha5);
        reg_read(6'h30, 8'ha5);
        reg_write(6'h3f, 8'h5a);
        reg_read(6'h3f, 8'h00);
        reg_write(LNBG_NR1_ADDR, 8'hff);
        reg_read(LNBG_NR1_ADDR, 8'hff);
        reg_write(LNBG_NR1_ADDR, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_gamma();
        logic [7:0] pts [7] = '{8'h28, 8'h46, 8'h64, 8'h82, 8'ha0, 8'hbe, 8'hdc};
        logic [7:0] xs [8] = '{8'h08, 8'h10, 8'h18, 8'h20, 8'h30, 8'he8, 8'hf0, 8'hfa};
        logic [7:0] ex [8] = '{8'h08, 8'h10, 8'h1c, 8'h28, 8'h37, 8'he6, 8'hf0, 8'hfa};
        for (int i = 0; i < 7; i++) reg_write(LNBG_GAMMA_ADDR + 6'(i), pts[i]);
        gamma_en = 1'b1;
        for (int i = 0; i < 8; i++) xfer(1'b1, xs[i], ex[i]);
        xfer(1'b1, 8'h40, 8'h46);
        xfer(1'b0, 8'h30, 8'h30);
        reg_write(LNBG_GAMMA_ADDR + 6'h07, 8'h32);
        curve_b = 1'b1;
        xfer(1'b1, 8'h20, 8'h28);
        i_src.field_end();
        xfer(1'b1, 8'h20, 8'h32);
        curve_b = 1'b0;
        i_src.field_end();
        gamma_en = 1'b0;
        $display("test gamma done");
    endtask
    task automatic t_bright();
        logic [7:0] ys [5] = '{8'h0a, 8'h14, 8'h1e, 8'h29, 8'hc8};
        i_src.field_end();
        for (int i = 0; i < 5; i++) i_src.send(i < 4, ys[i]);
        i_src.field_end();
        repeat (12) @(posedge clk);
        reg_read(LNBG_BRIGHT_ADDR, 8'h19);
        i_src.send(1'b1, 8'h3c);
        i_src.send(1'b1, 8'h3d);
        i_src.field_end();
        repeat (12) @(posedge clk);
        reg_read(LNBG_BRIGHT_ADDR, 8'h3c);
        i_src.got.delete();
        $display("test brightness done");
    endtask
    task automatic t_noise();
        reg_write(LNBG_NR0_ADDR, 8'h88);
        reg_write(LNBG_NR1_ADDR, 8'h0a);
        reg_write(LNBG_NR2_ADDR, 8'h00);
        xfer(1'b1, 8'h64, 8'h64);
        xfer(1'b1, 8'h68, 8'h66);
        xfer(1'b1, 8'h90, 8'h90);
        reg_write(LNBG_NR2_ADDR, 8'h08);
        reg_write(LNBG_NR1_ADDR, 8'h01);
        xfer(1'b1, 8'h64, 8'h59);
        xfer(1'b1, 8'h78, 8'h7d);
        xfer(1'b1, 8'h79, 8'h79);
        reg_write(LNBG_NR2_ADDR, 8'h01);
        reg_write(LNBG_NR1_ADDR, 8'h0a);
        xfer(1'b1, 8'h64, 8'h64);
        xfer(1'b1, 8'h32, 8'h32);
        xfer(1'b1, 8'h68, 8'h66);
        reg_write(LNBG_NR0_ADDR, 8'h80);
        reg_write(LNBG_NR2_ADDR, 8'h00);
        xfer(1'b0, 8'h64, 8'h64);
        xfer(1'b1, 8'h68, 8'h68);
        xfer(1'b1, 8'h6c, 8'h6a);
        reg_write(LNBG_NR2_ADDR, 8'h60);
        xfer(1'b1, 8'h70, 8'h70);
        reg_write(LNBG_NR1_ADDR, 8'h8a);
        reg_write(LNBG_NR2_ADDR, 8'h50);
        xfer(1'b1, 8'h74, 8'h72);
        reg_write(LNBG_NR0_ADDR, 8'h00);
        $display("test noise done");
    endtask
    task automatic t_buffer();
        int n;
        n = 0;
        stall = 1'b1;
        fork
            begin
                i_src.send(1'b1, 8'h50);
                i_src.send(1'b1, 8'h51);
                i_src.send(1'b1, 8'h52);
            end
        join_none
        while (pix_ready !== 1'b0 && n < 30) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        @(posedge clk);
        #1;
        chk("ready when full", 8'h00, {7'h00, pix_ready});
        chk("source holds", 8'h01, {7'h00, pix_valid});
        chk("stalled output count", 8'h00, 8'(i_src.got.size()));
        stall = 1'b0;
        wait fork;
        repeat (4) @(posedge clk);
        chk("drained count", 8'h03, 8'(i_src.got.size()));
        for (int i = 0; i < 3 && i < i_src.got.size(); i++) chk("drain order", 8'h50 + 8'(i), i_src.got[i].y);
        $display("test buffer done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_gamma();
        t_bright();
        t_noise();
        t_buffer();
        give_verdict();
    end
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
